// >>> exc_entry_pkg.sv
// Purpose: shared constants and types for the exception entry unit
// Assumes: 32-bit status word, mode field in bits 4:0
// Notes:   mask bit positions are fixed here for the whole core
package exc_entry_pkg;

   localparam int WORD_W = 32;

   // ***********************
   // status word layout
   // ***********************
   localparam int MODE_LSB  = 0;
   localparam int MODE_W    = 5;
   localparam int FMASK_BIT = 6;
   localparam int IMASK_BIT = 7;

   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1b;

   localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;

   // ***********************
   // vectors and link offsets
   // ***********************
   localparam logic [31:0] VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
   localparam logic [31:0] VEC_SOFT  = 32'h0000_0008;
   localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
   localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
   localparam logic [31:0] VEC_RSVD  = 32'h0000_0014;
   localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
   localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;
   localparam logic [31:0] LINK_OFS_SHORT = 32'h0000_0004;
   localparam logic [31:0] LINK_OFS_DABT  = 32'h0000_0008;
   localparam logic [31:0] WORD_STEP      = 32'h0000_0004;

   // ***********************
   // banks
   // ***********************
   localparam logic [2:0] BANK_FIQ  = 3'h0;
   localparam logic [2:0] BANK_IRQ  = 3'h1;
   localparam logic [2:0] BANK_SVC  = 3'h2;
   localparam logic [2:0] BANK_ABT  = 3'h3;
   localparam logic [2:0] BANK_UND  = 3'h4;
   localparam logic [2:0] BANK_NONE = 3'h5;
   localparam int N_BANKS = 5;

   // ***********************
   // latency figures, processor cycles
   // ***********************
   localparam int T_SYNC_MAX = 3;
   localparam int T_SYNC_MIN = 2;
   localparam int T_LDM      = 20;
   localparam int T_EXC      = 3;
   localparam int T_FIQ      = 2;
   localparam int LAT_MAX    = T_SYNC_MAX + T_LDM + T_EXC + T_FIQ;
   localparam int LAT_MIN    = 4;

   typedef enum logic [2:0] {
      EXC_NONE, EXC_RESET, EXC_DABT, EXC_FIQ, EXC_IRQ, EXC_PABT, EXC_UNDEF, EXC_SOFT
   } exc_kind_type;

   typedef struct packed {
      logic [31:0] vector;
      logic [4:0]  mode;
      logic        set_f;
      logic [2:0]  bank;
   } entry_type;

   // per-instruction information from the core
   typedef struct packed {
      logic        instr_end;
      logic        soft_trap;
      logic        undef_found;
      logic        is_swap;
      logic        restore_status;
      logic [31:0] cur_addr;
      logic [31:0] next_addr;
   } instr_info_type;

   // memory access cycle qualifiers
   typedef struct packed {
      logic fetch_cycle;
      logic data_cycle;
      logic pipe_advance;
      logic pipe_flush;
      logic fetch_ack;
   } mem_info_type;

   // write-back gating to the register file
   typedef struct packed {
      logic reg_write_en;
      logic base_write_en;
   } wb_ctrl_type;

endpackage

// >>> cpu_exception_entry_unit.sv
// Purpose: exception entry logic: sampling, priority, banking, vectoring
// Assumes: abort_in and core strobes are on sys_clk; request pins are not
// Notes:   core stalls while exc_busy is high
`timescale 1ns/1ps
module cpu_exception_entry_unit #(
   parameter int PIPE_DEPTH = 2,
   parameter int EXC_CYCLES = exc_entry_pkg::T_EXC,
   parameter int FIQ_CYCLES = exc_entry_pkg::T_FIQ
) (
   // clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rst,
   // pins from outside the clock domain
   input  wire logic                         sys_reset_low,
   input  wire logic                         fast_int_req_n,
   input  wire logic                         normal_int_req_n,
   // memory system
   input  wire logic                         abort_in,
   input  wire exc_entry_pkg::mem_info_type  mem_info,
   // core
   input  wire exc_entry_pkg::instr_info_type instr_info,
   input  wire logic                         status_wr,
   input  wire logic [31:0]                  status_wdata,
   // coprocessors
   input  wire logic                         cop_capable,
   input  wire logic                         cop_busy,
   output logic                              cop_offer,
   // fetch redirect
   output logic                              fetch_load,
   output logic [31:0]                       fetch_addr,
   // state seen by the core
   output logic                              exc_busy,
   output exc_entry_pkg::exc_kind_type       taken_kind,
   output logic [31:0]                       current_status_word,
   output logic [31:0]                       cur_link,
   output logic [31:0]                       cur_saved,
   output exc_entry_pkg::wb_ctrl_type        wb_ctrl
);
   import exc_entry_pkg::*;

   // ***********************
   // elaboration checks
   // ***********************
   if (PIPE_DEPTH < 1 || EXC_CYCLES < 1 || EXC_CYCLES > T_EXC ||
       FIQ_CYCLES < 1 || FIQ_CYCLES > T_FIQ) begin : g_bad_param
      $error("exception unit parameter out of range");
   end
   if (T_SYNC_MAX + T_LDM + EXC_CYCLES + FIQ_CYCLES > LAT_MAX ||
       T_SYNC_MIN + FIQ_CYCLES != LAT_MIN) begin : g_bad_latency
      $error("exception unit latency budget broken");
   end

   typedef enum {ST_RUN, ST_OFFER, ST_ENTRY, ST_RESET} state_type;

   function automatic entry_type entry_of(input exc_kind_type k);
      entry_type e;
      e = '{vector: VEC_SOFT, mode: MODE_SVC, set_f: 1'b0, bank: BANK_SVC};
      case (k)
         EXC_FIQ:   e = '{VEC_FIQ,   MODE_FIQ, 1'b1, BANK_FIQ};
         EXC_IRQ:   e = '{VEC_IRQ,   MODE_IRQ, 1'b0, BANK_IRQ};
         EXC_DABT:  e = '{VEC_DABT,  MODE_ABT, 1'b0, BANK_ABT};
         EXC_PABT:  e = '{VEC_PABT,  MODE_ABT, 1'b0, BANK_ABT};
         EXC_UNDEF: e = '{VEC_UNDEF, MODE_UND, 1'b0, BANK_UND};
         EXC_RESET: e = '{VEC_RESET, MODE_SVC, 1'b1, BANK_SVC};
         default:   e = '{VEC_SOFT,  MODE_SVC, 1'b0, BANK_SVC};
      endcase
      return e;
   endfunction

   function automatic logic [2:0] bank_of(input logic [4:0] m);
      case (m)
         MODE_FIQ: return BANK_FIQ;
         MODE_IRQ: return BANK_IRQ;
         MODE_SVC: return BANK_SVC;
         MODE_ABT: return BANK_ABT;
         MODE_UND: return BANK_UND;
         default:  return BANK_NONE;
      endcase
   endfunction

   // mode forced, normal mask always set, fast mask on request
   function automatic logic [31:0] enter_status(input logic [31:0] s, input entry_type e);
      logic [31:0] r;
      r = s;
      r[MODE_LSB +: MODE_W] = e.mode;
      r[IMASK_BIT] = 1'b1;
      r[FMASK_BIT] = s[FMASK_BIT] | e.set_f;
      return r;
   endfunction

   // ***********************
   // registers
   // ***********************
   state_type            state_reg;
   exc_kind_type         kind_reg;
   logic [3:0]           cnt_reg;
   logic                 fiq_meta_reg, fiq_sync_reg;
   logic                 irq_meta_reg, irq_sync_reg;
   logic                 rstn_meta_reg, rstn_sync_reg;
   logic                 dabt_reg;
   logic                 ptag_fetch_reg;
   logic [PIPE_DEPTH-1:0] ptag_reg;
   logic [31:0]          status_reg;
   logic [31:0]          fetch_addr_reg;
   logic                 fetch_load_reg;
   logic [31:0]          link_mem  [N_BANKS];
   logic [31:0]          saved_mem [N_BANKS];

   // ***********************
   // decode and selection
   // ***********************
   wire logic fiq_ok = !fiq_sync_reg && !status_reg[FMASK_BIT];
   wire logic irq_ok = !irq_sync_reg && !status_reg[IMASK_BIT];
   wire logic pabt_head = ptag_reg[PIPE_DEPTH-1];
   wire logic boundary = state_reg == ST_RUN && instr_info.instr_end;
   wire logic entry_done = state_reg == ST_ENTRY && cnt_reg == 4'h0;

   // reset handled apart; the reserved vector has no source
   wire exc_kind_type pick =
      dabt_reg            ? EXC_DABT :
      fiq_ok              ? EXC_FIQ  :
      irq_ok              ? EXC_IRQ  :
      pabt_head           ? EXC_PABT :
      instr_info.soft_trap ? EXC_SOFT : EXC_NONE;

   // a busy coprocessor wait gives way to an interrupt
   wire exc_kind_type offer_kind =
      !cop_capable           ? EXC_UNDEF :
      !cop_busy              ? EXC_NONE  :
      fiq_ok                 ? EXC_FIQ   :
      irq_ok                 ? EXC_IRQ   : EXC_NONE;
   wire logic offer_leave = state_reg == ST_OFFER && (!cop_capable || !cop_busy ||
                                                    fiq_ok || irq_ok);

   // fast entry straight after a data abort entry
   wire logic chain_fiq = entry_done && kind_reg == EXC_DABT && fiq_ok;

   wire exc_kind_type start_kind =
      chain_fiq                  ? EXC_FIQ    :
      state_reg == ST_OFFER      ? offer_kind :
      boundary && !instr_info.undef_found ? pick : EXC_NONE;
   wire logic start = start_kind != EXC_NONE && rstn_sync_reg;
   wire entry_type ent = entry_of(start_kind);

   // interrupted instruction is resumed: next for end, current for offer
   wire logic [31:0] resume_addr =
      chain_fiq              ? VEC_DABT :
      state_reg == ST_OFFER  ? instr_info.cur_addr : instr_info.next_addr;
   wire logic [31:0] link_val =
      start_kind == EXC_DABT ? instr_info.cur_addr + LINK_OFS_DABT :
      (start_kind == EXC_FIQ || start_kind == EXC_IRQ) ?
                               resume_addr + LINK_OFS_SHORT :
                               instr_info.cur_addr + LINK_OFS_SHORT;
   wire logic [3:0] entry_len =
      start_kind == EXC_FIQ ? 4'(FIQ_CYCLES - 1) : 4'(EXC_CYCLES - 1);

   wire logic [2:0] cur_bank = bank_of(status_reg[MODE_LSB +: MODE_W]);
   wire logic reset_release = state_reg == ST_RESET && rstn_sync_reg;
   wire entry_type rst_ent = entry_of(EXC_RESET);

   // ***********************
   // pin synchronisers
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fiq_meta_reg  <= 1'b1;
         fiq_sync_reg  <= 1'b1;
         irq_meta_reg  <= 1'b1;
         irq_sync_reg  <= 1'b1;
         rstn_meta_reg <= 1'b0;
         rstn_sync_reg <= 1'b0;
      end else begin
         fiq_meta_reg  <= fast_int_req_n;
         fiq_sync_reg  <= fiq_meta_reg;
         irq_meta_reg  <= normal_int_req_n;
         irq_sync_reg  <= irq_meta_reg;
         rstn_meta_reg <= sys_reset_low;
         rstn_sync_reg <= rstn_meta_reg;
      end
   end

   // ***********************
   // abort capture
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dabt_reg       <= 1'b0;
         ptag_fetch_reg <= 1'b0;
         ptag_reg       <= '0;
      end else begin
         // a fresh abort wins over the clear of the taken one
         if (mem_info.data_cycle && abort_in)
            dabt_reg <= 1'b1;
         else if (start && start_kind == EXC_DABT)
            dabt_reg <= 1'b0;
         if (mem_info.fetch_cycle)
            ptag_fetch_reg <= abort_in;
         // flushed instructions drop their tag with them
         if (mem_info.pipe_flush || start || !rstn_sync_reg)
            ptag_reg <= '0;
         else if (mem_info.pipe_advance)
            ptag_reg <= PIPE_DEPTH'({ptag_reg, ptag_fetch_reg});
      end
   end

   // ***********************
   // state and sequencing
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg      <= ST_RESET;
         kind_reg       <= EXC_NONE;
         cnt_reg        <= 4'h0;
         fetch_addr_reg <= VEC_RESET;
         fetch_load_reg <= 1'b0;
      end else begin
         fetch_load_reg <= 1'b0;
         if (!rstn_sync_reg) begin
            state_reg <= ST_RESET;
            kind_reg  <= EXC_RESET;
            if (mem_info.fetch_ack) begin
               fetch_addr_reg <= fetch_addr_reg + WORD_STEP;
               fetch_load_reg <= 1'b1;
            end
         end else if (reset_release) begin
            state_reg      <= ST_RUN;
            fetch_addr_reg <= rst_ent.vector;
            fetch_load_reg <= 1'b1;
         end else if (start) begin
            state_reg      <= ST_ENTRY;
            kind_reg       <= start_kind;
            cnt_reg        <= entry_len;
            fetch_addr_reg <= ent.vector;
         end else begin
            case (state_reg)
               ST_RUN: begin
                  if (boundary && instr_info.undef_found)
                     state_reg <= ST_OFFER;
               end
               ST_OFFER: begin
                  if (offer_leave)
                     state_reg <= ST_RUN;
               end
               ST_ENTRY: begin
                  if (entry_done) begin
                     state_reg      <= ST_RUN;
                     fetch_load_reg <= 1'b1;
                  end else begin
                     cnt_reg <= cnt_reg - 4'h1;
                  end
               end
               default: state_reg <= ST_RUN;
            endcase
         end
      end
   end

   // ***********************
   // status word and banked copies
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_reg <= STATUS_RESET;
         for (int i = 0; i < N_BANKS; i++) begin
            link_mem[i]  <= '0;
            saved_mem[i] <= '0;
         end
      end else if (reset_release) begin
         link_mem[rst_ent.bank]  <= fetch_addr_reg;
         saved_mem[rst_ent.bank] <= status_reg;
         status_reg              <= enter_status(status_reg, rst_ent);
      end else if (start) begin
         link_mem[ent.bank]  <= link_val;
         saved_mem[ent.bank] <= status_reg;
         status_reg          <= enter_status(status_reg, ent);
      end else if (state_reg == ST_RUN && instr_info.restore_status &&
                   cur_bank != BANK_NONE) begin
         status_reg <= saved_mem[cur_bank];
      end else if (state_reg == ST_RUN && status_wr) begin
         status_reg <= status_wdata;
      end
   end

   // ***********************
   // outputs
   // ***********************
   // base write-back survives an abort except for the swap
   assign wb_ctrl.reg_write_en  = !dabt_reg;
   assign wb_ctrl.base_write_en = !(dabt_reg && instr_info.is_swap);

   assign cop_offer           = state_reg == ST_OFFER;
   assign exc_busy            = state_reg != ST_RUN;
   assign fetch_load          = fetch_load_reg;
   assign fetch_addr          = fetch_addr_reg;
   assign taken_kind          = kind_reg;
   assign current_status_word = status_reg;
   assign cur_link  = cur_bank == BANK_NONE ? '0 : link_mem[cur_bank];
   assign cur_saved = cur_bank == BANK_NONE ? '0 : saved_mem[cur_bank];

endmodule // cpu_exception_entry_unit

// >>> cpu_exception_entry_unit_assertions.sv
// Purpose: port-level checks on the exception entry unit
// Assumes: entry takes three cycles, fast entry two
// Notes:   bound into every instance of the unit
`timescale 1ns/1ps
module exc_entry_checker (
   // clock and reset
   input wire logic                          sys_clk,
   input wire logic                          rst,
   // memory, core and coprocessor side
   input wire logic                          abort_in,
   input wire exc_entry_pkg::mem_info_type   mem_info,
   input wire exc_entry_pkg::instr_info_type instr_info,
   input wire logic                          cop_capable,
   input wire logic                          cop_busy,
   // unit outputs
   input wire logic                          cop_offer,
   input wire logic                          fetch_load,
   input wire logic [31:0]                   fetch_addr,
   input wire logic                          exc_busy,
   input wire exc_entry_pkg::exc_kind_type   taken_kind,
   input wire logic [31:0]                   current_status_word,
   input wire exc_entry_pkg::wb_ctrl_type    wb_ctrl
);
   import exc_entry_pkg::*;
   // ***************
   // entry steps
   // ***************
   logic [4:0] mode_now;
   logic       i_set;
   logic       f_set;
   assign mode_now = current_status_word[4:0];
   assign i_set    = current_status_word[IMASK_BIT];
   assign f_set    = current_status_word[FMASK_BIT];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // busy also rises for an offer, so offers are kept out
   sequence started(exc_kind_type k);
      $rose(exc_busy) && !cop_offer && taken_kind == k;
   endsequence
   sequence redirect(logic [31:0] a);
      fetch_load && fetch_addr == a;
   endsequence
   fast_entry_a: assert property (started(EXC_FIQ) |-> !$past(f_set)
      && mode_now == MODE_FIQ && i_set && f_set ##2 redirect(VEC_FIQ)) else $error("fast entry");
   normal_entry_a: assert property (started(EXC_IRQ) |-> mode_now == MODE_IRQ
      && i_set ##3 redirect(VEC_IRQ)) else $error("normal entry");
   pabt_entry_a: assert property (started(EXC_PABT) |-> mode_now == MODE_ABT
      && i_set ##3 redirect(VEC_PABT)) else $error("prefetch abort entry");
   dabt_entry_a: assert property (started(EXC_DABT) |-> (##3 redirect(VEC_DABT))
      or (##[2:3] taken_kind == EXC_FIQ)) else $error("data abort entry");
   soft_entry_a: assert property (started(EXC_SOFT) |-> mode_now == MODE_SVC
      && i_set ##3 redirect(VEC_SOFT)) else $error("soft trap entry");
   undef_entry_a: assert property (cop_offer && !cop_capable |=> taken_kind == EXC_UNDEF
      && mode_now == MODE_UND ##3 redirect(VEC_UNDEF)) else $error("undefined entry");
   offer_accept_a: assert property (cop_offer && cop_capable && !cop_busy
      |=> !cop_offer && !exc_busy) else $error("accepted offer kept");
   abort_gate_a: assert property (abort_in && mem_info.data_cycle
      |=> !wb_ctrl.reg_write_en) else $error("writes after data abort");
   swap_base_a: assert property (abort_in && mem_info.data_cycle
      |=> wb_ctrl.base_write_en == !instr_info.is_swap) else $error("base write gating");
   no_rsvd_a: assert property (fetch_load |-> fetch_addr != VEC_RSVD)
      else $error("reserved vector used");
endmodule // exc_entry_checker

bind cpu_exception_entry_unit exc_entry_checker u_exc_entry_checker (
   .sys_clk(sys_clk), .rst(rst), .abort_in(abort_in), .mem_info(mem_info),
   .instr_info(instr_info), .cop_capable(cop_capable), .cop_busy(cop_busy),
   .cop_offer(cop_offer), .fetch_load(fetch_load), .fetch_addr(fetch_addr),
   .exc_busy(exc_busy), .taken_kind(taken_kind),
   .current_status_word(current_status_word), .wb_ctrl(wb_ctrl)
);

// >>> exc_source_model.sv
// Purpose: interrupt sources and aborting memory beside the unit
// Assumes: bench requests change at the falling clock edge
// Notes:   pins move 1.7 ns later, out of step with the clock
`timescale 1ns/1ps
module exc_source_model (
   // requests from the bench
   input wire logic                        fiq_lvl,
   input wire logic                        irq_lvl,
   input wire logic [1:0]                  abt_kind,
   input wire logic                        adv,
   input wire logic                        flush,
   input wire logic                        ack,
   // toward the unit
   output logic                            fast_int_req_n,
   output logic                            normal_int_req_n,
   output logic                            abort_in,
   output exc_entry_pkg::mem_info_type     mem_info
);
   import exc_entry_pkg::*;
   assign #1.7 fast_int_req_n   = !fiq_lvl;
   assign #1.7 normal_int_req_n = !irq_lvl;
   // a fetch runs every cycle that is not a data access
   assign abort_in = abt_kind != 2'h0;
   assign mem_info = {abt_kind != 2'h2, abt_kind == 2'h2, adv, flush, ack};
endmodule // exc_source_model

// >>> cpu_exception_entry_unit_bench.sv
// Purpose: directed tests of exception entry at the unit ports
// Assumes: default entry latencies, pipeline depth of two
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module cpu_exception_entry_unit_bench;
   import exc_entry_pkg::*;
   localparam logic [31:0] OPEN = 32'h0000_0013;
   logic sys_clk = 1'b0, rst = 1'b1, sys_reset_low = 1'b0, fiq_lvl = 1'b0, irq_lvl = 1'b0;
   logic adv = 1'b0, flush = 1'b0, ack = 1'b0, status_wr = 1'b0;
   logic cop_capable = 1'b0, cop_busy = 1'b0, fast_int_req_n, normal_int_req_n, abort_in;
   logic cop_offer, fetch_load, exc_busy;
   logic [1:0] abt_kind = 2'h0;
   logic [31:0] status_wdata = 32'h0, fetch_addr, current_status_word, cur_link, cur_saved;
   instr_info_type info = '0;
   mem_info_type mem_info;
   exc_kind_type taken_kind;
   wb_ctrl_type wb_ctrl;
   int error_cnt = 0, check_count = 0, cyc = 0, n;

   cpu_exception_entry_unit #(.PIPE_DEPTH(2)) u_cpu_exception_entry_unit (
      .sys_clk(sys_clk), .rst(rst), .sys_reset_low(sys_reset_low),
      .fast_int_req_n(fast_int_req_n), .normal_int_req_n(normal_int_req_n),
      .abort_in(abort_in), .mem_info(mem_info), .instr_info(info),
      .status_wr(status_wr), .status_wdata(status_wdata), .cop_capable(cop_capable),
      .cop_busy(cop_busy), .cop_offer(cop_offer), .fetch_load(fetch_load),
      .fetch_addr(fetch_addr), .exc_busy(exc_busy), .taken_kind(taken_kind),
      .current_status_word(current_status_word), .cur_link(cur_link),
      .cur_saved(cur_saved), .wb_ctrl(wb_ctrl));
   exc_source_model u_exc_source_model (
      .fiq_lvl(fiq_lvl), .irq_lvl(irq_lvl), .abt_kind(abt_kind), .adv(adv),
      .flush(flush), .ack(ack), .fast_int_req_n(fast_int_req_n),
      .normal_int_req_n(normal_int_req_n), .abort_in(abort_in), .mem_info(mem_info));

   // ***************
   // shared tasks
   // ***************
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         complete_run();
      end
   end
   function automatic logic [31:0] mk(input logic i, f, input logic [4:0] m);
      return {24'h0, i, f, 1'b0, m};
   endfunction
   task automatic chk(input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wcyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   task automatic pend(input logic sw, un);
      info.instr_end = 1'b1;
      info.soft_trap = sw;
      info.undef_found = un;
      @(negedge sys_clk);
      info.instr_end = 1'b0;
      info.soft_trap = 1'b0;
      info.undef_found = 1'b0;
      @(negedge sys_clk);
   endtask
   // boundaries repeat until the unit goes busy, then the redirect is checked
   task automatic entry(input string s, input logic sw, un,
                        input logic [31:0] vec, st, lnk, svd, output int cnt);
      info.instr_end = 1'b1;
      info.soft_trap = sw;
      info.undef_found = un;
      cnt = 0;
      do begin
         @(negedge sys_clk);
         cnt++;
         if (exc_busy === 1'b1) begin
            info.instr_end = 1'b0;
            info.soft_trap = 1'b0;
            info.undef_found = 1'b0;
         end
      end while (fetch_load !== 1'b1 && cnt < 60);
      chk(fetch_addr, vec);
      chk(current_status_word, st);
      chk(cur_link, lnk);
      chk(cur_saved, svd);
      $display("test %s done", s);
   endtask
   task automatic ret(input logic [31:0] exp);
      @(negedge sys_clk);
      info.restore_status = 1'b1;
      @(negedge sys_clk);
      info.restore_status = 1'b0;
      @(negedge sys_clk);
      chk(current_status_word, exp);
   endtask
   task automatic wst(input logic [31:0] v);
      status_wr = 1'b1;
      status_wdata = v;
      @(negedge sys_clk);
      status_wr = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic abt(input logic [1:0] k, input int steps);
      abt_kind = k;
      @(negedge sys_clk);
      abt_kind = 2'h0;
      repeat (steps) begin
         adv = 1'b1;
         @(negedge sys_clk);
         adv = 1'b0;
         @(negedge sys_clk);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ***************
   // test sequence
   // ***************
   initial begin
      info.cur_addr = 32'h0000_0200;
      info.next_addr = 32'h0000_0204;
      wcyc(20);
      rst = 1'b0;
      for (int k = 1; k <= 3; k++) begin
         ack = 1'b1;
         @(negedge sys_clk);
         ack = 1'b0;
         chk(fetch_load, 1'b1);
         chk(fetch_addr, 32'(4 * k));
         @(negedge sys_clk);
      end
      sys_reset_low = 1'b1;
      entry("reset", 0, 0, VEC_RESET, mk(1, 1, MODE_SVC), 32'hc, STATUS_RESET, n);
      wst(OPEN);
      entry("soft", 1, 0, VEC_SOFT, mk(1, 0, MODE_SVC), 32'h204, OPEN, n);
      ret(OPEN);
      fiq_lvl = 1'b1;
      irq_lvl = 1'b1;
      entry("fast", 0, 0, VEC_FIQ, mk(1, 1, MODE_FIQ), 32'h208, OPEN, n);
      chk(n - 1, LAT_MIN);
      fiq_lvl = 1'b0;
      wcyc(3);
      ret(OPEN);
      entry("normal", 0, 0, VEC_IRQ, mk(1, 0, MODE_IRQ), 32'h208, OPEN, n);
      irq_lvl = 1'b0;
      wcyc(3);
      ret(OPEN);
      wst(mk(0, 1, MODE_SVC));
      fiq_lvl = 1'b1;
      wcyc(3);
      pend(0, 0);
      wcyc(3);
      chk(exc_busy, 1'b0);
      chk(current_status_word, mk(0, 1, MODE_SVC));
      $display("test mask done");
      wst(OPEN);
      abt(2'h2, 0);
      chk(wb_ctrl.reg_write_en, 1'b0);
      chk(wb_ctrl.base_write_en, 1'b1);
      entry("chain", 0, 0, VEC_FIQ, mk(1, 1, MODE_FIQ), 32'h14, mk(1, 0, MODE_ABT), n);
      chk(wb_ctrl.reg_write_en, 1'b1);
      fiq_lvl = 1'b0;
      wcyc(3);
      ret(mk(1, 0, MODE_ABT));
      chk(cur_link, 32'h208);
      ret(OPEN);
      info.is_swap = 1'b1;
      abt(2'h2, 0);
      chk(wb_ctrl.base_write_en, 1'b0);
      entry("swap", 0, 0, VEC_DABT, mk(1, 0, MODE_ABT), 32'h208, OPEN, n);
      info.is_swap = 1'b0;
      ret(OPEN);
      abt(2'h1, 2);
      flush = 1'b1;
      @(negedge sys_clk);
      flush = 1'b0;
      pend(0, 0);
      wcyc(3);
      chk(exc_busy, 1'b0);
      abt(2'h1, 2);
      entry("prefetch", 0, 0, VEC_PABT, mk(1, 0, MODE_ABT), 32'h204, OPEN, n);
      ret(OPEN);
      cop_capable = 1'b1;
      pend(0, 1);
      wcyc(2);
      chk(exc_busy, 1'b0);
      cop_busy = 1'b1;
      pend(0, 1);
      wcyc(3);
      chk(cop_offer, 1'b1);
      cop_capable = 1'b0;
      cop_busy = 1'b0;
      entry("undef", 0, 0, VEC_UNDEF, mk(1, 0, MODE_UND), 32'h204, OPEN, n);
      ret(OPEN);
      complete_run();
   end
endmodule // cpu_exception_entry_unit_bench
